//--- hdl/aspl_regs.vh
// Purpose: Offsets, fields, reset values and timing counts of the amplifier status block
// Assumes: 20 MHz system clock
// Notes: Register byte addresses are word aligned
`ifndef ASPL_REGS_VH
`define ASPL_REGS_VH
`define ASPL_CLK_HZ 20000000
// Register byte offsets
`define ASPL_OFF_CTRL 12'h000
`define ASPL_OFF_STATUS 12'h004
`define ASPL_OFF_CAUSE 12'h008
`define ASPL_OFF_TEMP 12'h00c
// Control fields
`define ASPL_CTRL_SLEEP 0
`define ASPL_CTRL_WAKE 1
`define ASPL_CTRL_SINGLE 2
`define ASPL_CTRL_RESET 32'h0000_0000
// Fault cause bits
`define ASPL_F_SUPPLY 0
`define ASPL_F_OVERCUR 1
`define ASPL_F_OVERHEAT 2
`define ASPL_F_SONIC 3
`define ASPL_F_ANALOG 4
`define ASPL_F_CONTROL 5
// Times in microseconds, counts in cycles
`define ASPL_CLIP_MIN_US 50000
`define ASPL_SLEEP_REL_US 100000
`define ASPL_RUN_REL_US 100000
`define ASPL_RESTART_US 500000
`define ASPL_US2CYC(t) ((t) * (`ASPL_CLK_HZ / 1000000))
`endif

//--- hdl/aspl_stretch.v
// Purpose: Holds a level for at least a minimum number of cycles
// Assumes: Event level is already synchronous
// Notes: Active output is high; caller drives the pin enable with it
`timescale 1ns/1ps
module aspl_stretch #(
  parameter W = 24,
  parameter [W-1:0] MIN_CYC = 24'd1
)
(
  input wire clock_i,
  input wire rst_n_i,
  input wire event_i,
  output wire hold_o
);
reg [W-1:0] cnt_reg;
reg hold_reg;
always @(posedge clock_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    cnt_reg <= {W{1'b0}};
    hold_reg <= 1'b0;
  end
  else if (event_i)
  begin
    cnt_reg <= MIN_CYC - 1'b1;
    hold_reg <= 1'b1;
  end
  else if (cnt_reg != {W{1'b0}})
  begin
    cnt_reg <= cnt_reg - 1'b1;
  end
  else
  begin
    hold_reg <= 1'b0;
  end
end
assign hold_o = hold_reg;
endmodule // aspl_stretch

//--- hdl/aspl_sync.v
// Purpose: Two flip-flop synchroniser for a bus of levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage read only by second stage
`timescale 1ns/1ps
module aspl_sync #(
  parameter W = 1
)
(
  input wire clock_i,
  input wire rst_n_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
reg [W-1:0] meta_reg;
reg [W-1:0] sync_reg;
always @(posedge clock_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    meta_reg <= {W{1'b0}};
    sync_reg <= {W{1'b0}};
  end
  else
  begin
    meta_reg <= async_i;
    sync_reg <= meta_reg;
  end
end
assign sync_o = sync_reg;
endmodule // aspl_sync

//--- hdl/aspl_top.v
// Purpose: Status indicators and protective restart sequencing of an amplifier module
// Assumes: One 20 MHz clock, APB register access, pins pulled up outside
// Notes: Open-drain pins are value low plus enable; the wire level is resolved outside
`timescale 1ns/1ps
`include "aspl_regs.vh"
module aspl_top #(
  parameter [31:0] CLIP_MIN_CYC = `ASPL_US2CYC(`ASPL_CLIP_MIN_US),
  parameter [31:0] SLEEP_REL_CYC = `ASPL_US2CYC(`ASPL_SLEEP_REL_US),
  parameter [31:0] RUN_REL_CYC = `ASPL_US2CYC(`ASPL_RUN_REL_US),
  parameter [31:0] RESTART_CYC = `ASPL_US2CYC(`ASPL_RESTART_US)
)
(
  input wire clock_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [1:0] clip_detect_i,
  input wire supply_abnormal_i,
  input wire overcurrent_i,
  input wire amp_overheat_i,
  input wire supply_overheat_i,
  input wire amp_below_clear_i,
  input wire supply_below_clear_i,
  input wire sonic_excess_i,
  input wire analog_aux_overload_i,
  input wire control_aux_overload_i,
  input wire mains_present_i,
  input wire sleep_req_i,
  input wire remote_wake_i,
  input wire audio_presence_in_i,
  input wire checks_passed_i,
  output wire ch1_saturation_flag_n_o,
  output wire ch1_saturation_flag_oe_o,
  output wire ch2_saturation_flag_n_o,
  output wire ch2_saturation_flag_oe_o,
  output wire fault_flag_n_o,
  output wire fault_flag_oe_o,
  output wire sleep_flag_n_o,
  output wire sleep_flag_oe_o,
  output wire running_flag_n_o,
  output wire running_flag_oe_o,
  output wire power_stage_ok_n_o,
  output wire power_stage_ok_oe_o,
  output reg amp_enable_o,
  output reg analog_aux_enable_o,
  output reg control_aux_enable_o
);
////////////////////////////////////////////////////////////////////////////////
localparam ST_RUN = 4'b0001;
localparam ST_ANALOG = 4'b0010;
localparam ST_POWEROFF = 4'b0100;
localparam ST_WAIT = 4'b1000;
localparam NSYNC = 16;
wire [NSYNC-1:0] raw_in;
wire [NSYNC-1:0] syn;
wire [1:0] clip_s;
wire [5:0] cause;
wire wake_s;
wire sleep_s;
wire mains_s;
wire checks_s;
wire fault_any;
wire overheat_block;
wire [1:0] clip_hold;
wire sel_ok;
reg [31:0] ctrl_reg;
reg [5:0] cause_reg;
reg [3:0] state_reg;
reg [3:0] state_next;
reg [31:0] seq_cnt_reg;
reg overheat_latch_reg;
reg sleeping_reg;
reg sleep_flag_reg;
reg running_flag_reg;
reg [31:0] sleep_cnt_reg;
reg [31:0] run_cnt_reg;
reg fault_flag_reg;
reg stage_ok_reg;
////////////////////////////////////////////////////////////////////////////////
// Every outside status level crosses two flops first; APB inputs are used directly
assign raw_in = {checks_passed_i, mains_present_i, audio_presence_in_i, remote_wake_i, sleep_req_i,
  control_aux_overload_i, analog_aux_overload_i, sonic_excess_i, supply_below_clear_i,
  amp_below_clear_i, supply_overheat_i, amp_overheat_i, overcurrent_i, supply_abnormal_i, clip_detect_i};
aspl_sync #(
  .W(NSYNC)
) u_sync (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .async_i(raw_in),
  .sync_o(syn)
);
assign clip_s = syn[1:0];
assign cause = {syn[10], syn[9], syn[8], syn[5] | syn[4], syn[3], syn[2]};
assign sleep_s = syn[11] | ctrl_reg[`ASPL_CTRL_SLEEP];
assign wake_s = syn[12] | syn[13] | ctrl_reg[`ASPL_CTRL_WAKE];
assign mains_s = syn[14];
assign checks_s = syn[15];
assign fault_any = |cause;
// Overheat keeps blocking until both sensors report cool
assign overheat_block = overheat_latch_reg & ~(syn[6] & syn[7]);
////////////////////////////////////////////////////////////////////////////////
// Clip stretchers, one per channel
genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1)
  begin : g_clip
    aspl_stretch #(
      .W(32),
      .MIN_CYC(CLIP_MIN_CYC)
    ) u_str (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .event_i(clip_s[gi]),
      .hold_o(clip_hold[gi])
    );
  end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// Protection sequencer
always @*
begin
  state_next = state_reg;
  case (state_reg)
    ST_RUN:
    begin
      if (cause[`ASPL_F_CONTROL])
        state_next = ST_POWEROFF;
      else if (cause[`ASPL_F_ANALOG])
        state_next = ST_ANALOG;
      else if (fault_any)
        state_next = ST_WAIT;
    end
    ST_ANALOG:
    begin
      if (!cause[`ASPL_F_ANALOG])
        state_next = ST_WAIT;
    end
    ST_POWEROFF:
    begin
      if (!cause[`ASPL_F_CONTROL])
        state_next = ST_WAIT;
    end
    ST_WAIT:
    begin
      if (cause[`ASPL_F_CONTROL])
        state_next = ST_POWEROFF;
      else if (fault_any || overheat_block)
        state_next = ST_WAIT;
      else if (seq_cnt_reg == 32'h0000_0000)
        state_next = ST_RUN;
    end
    default:
      state_next = ST_RUN;
  endcase
end
always @(posedge clock_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    state_reg <= ST_RUN;
    seq_cnt_reg <= 32'h0000_0000;
    overheat_latch_reg <= 1'b0;
  end
  else
  begin
    state_reg <= state_next;
    if (state_next == ST_WAIT && (state_reg != ST_WAIT || fault_any || overheat_block))
      seq_cnt_reg <= RESTART_CYC;
    else if (seq_cnt_reg != 32'h0000_0000)
      seq_cnt_reg <= seq_cnt_reg - 32'h0000_0001;
    if (cause[`ASPL_F_OVERHEAT])
      overheat_latch_reg <= 1'b1;
    else if (syn[6] && syn[7])
      overheat_latch_reg <= 1'b0;
  end
end
////////////////////////////////////////////////////////////////////////////////
// Sleep, running and fault flags, enables and power stage ok
always @(posedge clock_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    sleeping_reg <= 1'b0;
    sleep_flag_reg <= 1'b0;
    running_flag_reg <= 1'b0;
    sleep_cnt_reg <= 32'h0000_0000;
    run_cnt_reg <= 32'h0000_0000;
    fault_flag_reg <= 1'b0;
    stage_ok_reg <= 1'b0;
    amp_enable_o <= 1'b0;
    analog_aux_enable_o <= 1'b0;
    control_aux_enable_o <= 1'b0;
  end
  else
  begin
    sleeping_reg <= (sleep_s & ~wake_s) | ~mains_s;
    if (sleeping_reg)
    begin
      sleep_flag_reg <= 1'b1;
      sleep_cnt_reg <= SLEEP_REL_CYC;
    end
    else if (sleep_cnt_reg != 32'h0000_0000)
      sleep_cnt_reg <= sleep_cnt_reg - 32'h0000_0001;
    else
      sleep_flag_reg <= 1'b0;
    if (!sleeping_reg)
    begin
      running_flag_reg <= 1'b1;
      run_cnt_reg <= RUN_REL_CYC;
    end
    else if (run_cnt_reg != 32'h0000_0000)
      run_cnt_reg <= run_cnt_reg - 32'h0000_0001;
    else
      running_flag_reg <= 1'b0;
    fault_flag_reg <= (state_reg != ST_RUN) & (state_reg != ST_POWEROFF | cause[`ASPL_F_CONTROL]);
    amp_enable_o <= ~sleeping_reg & (state_reg == ST_RUN);
    analog_aux_enable_o <= ~sleeping_reg & (state_reg == ST_RUN | state_reg == ST_WAIT);
    control_aux_enable_o <= state_reg != ST_POWEROFF;
    stage_ok_reg <= ~sleeping_reg & (state_reg == ST_RUN) & ~fault_any & checks_s;
  end
end
////////////////////////////////////////////////////////////////////////////////
// Open-drain pins: value always low, enable only while pulling
assign ch1_saturation_flag_n_o = 1'b0;
assign ch1_saturation_flag_oe_o = clip_hold[0];
assign ch2_saturation_flag_n_o = 1'b0;
assign ch2_saturation_flag_oe_o = clip_hold[1] & ~ctrl_reg[`ASPL_CTRL_SINGLE];
assign fault_flag_n_o = 1'b0;
assign fault_flag_oe_o = fault_flag_reg;
assign sleep_flag_n_o = 1'b0;
assign sleep_flag_oe_o = sleep_flag_reg;
assign running_flag_n_o = 1'b0;
assign running_flag_oe_o = running_flag_reg;
assign power_stage_ok_n_o = 1'b0;
assign power_stage_ok_oe_o = stage_ok_reg;
////////////////////////////////////////////////////////////////////////////////
// APB slave, zero wait states
assign pready_o = 1'b1;
assign sel_ok = (paddr_i == `ASPL_OFF_CTRL) || (paddr_i == `ASPL_OFF_STATUS) ||
  (paddr_i == `ASPL_OFF_CAUSE) || (paddr_i == `ASPL_OFF_TEMP);
assign pslverr_o = psel_i & penable_i & ~sel_ok;
always @(posedge clock_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    ctrl_reg <= `ASPL_CTRL_RESET;
    cause_reg <= 6'h00;
    prdata_o <= 32'h0000_0000;
  end
  else
  begin
    // Sticky cause: a new cause wins over a clear in the same cycle
    if (psel_i && penable_i && pwrite_i && paddr_i == `ASPL_OFF_CAUSE)
      cause_reg <= (cause_reg & ~pwdata_i[5:0]) | cause;
    else
      cause_reg <= cause_reg | cause;
    if (psel_i && penable_i && pwrite_i && paddr_i == `ASPL_OFF_CTRL)
      ctrl_reg <= {29'h0, pwdata_i[2:0]};
    if (psel_i && !penable_i && !pwrite_i)
    begin
      if (paddr_i == `ASPL_OFF_CTRL)
        prdata_o <= ctrl_reg;
      else if (paddr_i == `ASPL_OFF_STATUS)
        prdata_o <= {20'h0, state_reg, stage_ok_reg, running_flag_reg, sleep_flag_reg,
          fault_flag_reg, clip_hold, sleeping_reg, overheat_latch_reg};
      else if (paddr_i == `ASPL_OFF_CAUSE)
        prdata_o <= {26'h0, cause_reg};
      else if (paddr_i == `ASPL_OFF_TEMP)
        prdata_o <= {30'h0, syn[7], syn[6]};
      else
        prdata_o <= 32'h0000_0000;
    end
  end
end
endmodule // aspl_top

//--- sim/aspl_checker.sv
// Purpose: Timing checks on status pins
// Assumes: Bench delay parameters 8,10,10,20
// Notes: Bound from tb
`timescale 1ns/1ps
module aspl_checker (
  input wire clock_i,
  input wire rst_n_i,
  input wire [1:0] clip_detect_i,
  input wire overcurrent_i,
  input wire analog_aux_overload_i,
  input wire mains_present_i,
  input wire remote_wake_i,
  input wire ch1_saturation_flag_n_o,
  input wire ch1_saturation_flag_oe_o,
  input wire fault_flag_n_o,
  input wire fault_flag_oe_o,
  input wire sleep_flag_oe_o,
  input wire running_flag_oe_o,
  input wire power_stage_ok_oe_o,
  input wire amp_enable_o,
  input wire analog_aux_enable_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_wake;
    sleep_flag_oe_o ##1 (remote_wake_i && mains_present_i) [*5];
  endsequence
  chk_never_high: assert property (!ch1_saturation_flag_n_o && !fault_flag_n_o)
    else $error("pin high");
  chk_clip_low: assert property (clip_detect_i[0] [*4] |-> ##[0:4] ch1_saturation_flag_oe_o)
    else $error("clip late");
  chk_clip_width: assert property ($rose(ch1_saturation_flag_oe_o) |-> ch1_saturation_flag_oe_o [*4])
    else $error("clip short");
  chk_fault_cause: assert property (overcurrent_i [*3] |-> ##[0:6] fault_flag_oe_o)
    else $error("fault late");
  chk_fault_amp: assert property ($rose(fault_flag_oe_o) |-> ##[0:3] !amp_enable_o)
    else $error("amp on");
  chk_stage_drop: assert property (!amp_enable_o |-> ##[0:2] !power_stage_ok_oe_o)
    else $error("stage ok");
  chk_analog_drop: assert property (analog_aux_overload_i [*4] |-> ##[0:4] !analog_aux_enable_o && !amp_enable_o)
    else $error("aux on");
  chk_sleep_hold: assert property ($rose(remote_wake_i) && sleep_flag_oe_o |-> sleep_flag_oe_o [*8])
    else $error("sleep early");
  chk_run_fast: assert property (s_wake |-> ##[0:4] running_flag_oe_o)
    else $error("run late");
  chk_run_hold: assert property ($fell(mains_present_i) && running_flag_oe_o |-> running_flag_oe_o [*8])
    else $error("run early");
endmodule // aspl_checker

//--- sim/aspl_frontend.sv
// Purpose: Front end reading the status pins
// Assumes: Pull-up on every pin
// Notes: Bits stage,run,sleep,fault,ch2,ch1
`timescale 1ns/1ps
module aspl_frontend (
  input wire clock_i,
  input wire [5:0] oe_i,
  input wire [5:0] n_i,
  output wire [5:0] pin_o,
  output reg starting_o = 1'b0,
  output reg stopping_o = 1'b0
);
  reg [1:0] last = 2'b11;
  // Released pin floats up, never sees a stale level
  assign pin_o = ~(oe_i & ~n_i);
  always @(posedge clock_i)
  begin
    last <= pin_o[4:3];
    starting_o <= ~|pin_o[4:3] & (starting_o | last == 2'b10);
    stopping_o <= ~|pin_o[4:3] & (stopping_o | last == 2'b01);
  end
endmodule // aspl_frontend

//--- sim/tb.sv
// Purpose: Directed bench for the status block
// Assumes: 50 ns clock, small delays
// Notes: Pins read through the front end
`timescale 1ns/1ps
`include "aspl_regs.vh"
module tb;
  localparam CM = 8, SR = 10, RR = 10, RS = 20;
  reg clock_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  reg [11:0] paddr_i = 0;
  reg [31:0] pwdata_i = 0, rd;
  reg [1:0] clip_detect_i = 0;
  reg supply_abnormal_i = 0, overcurrent_i = 0, amp_overheat_i = 0, supply_overheat_i = 0, er;
  reg amp_below_clear_i = 1, supply_below_clear_i = 1, sonic_excess_i = 0, analog_aux_overload_i = 0;
  reg control_aux_overload_i = 0, mains_present_i = 1, sleep_req_i = 0, remote_wake_i = 0;
  reg audio_presence_in_i = 0, checks_passed_i = 1;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, amp_enable_o, analog_aux_enable_o, control_aux_enable_o;
  wire ch1_saturation_flag_n_o, ch1_saturation_flag_oe_o, ch2_saturation_flag_n_o, ch2_saturation_flag_oe_o;
  wire fault_flag_n_o, fault_flag_oe_o, sleep_flag_n_o, sleep_flag_oe_o, starting, stopping;
  wire running_flag_n_o, running_flag_oe_o, power_stage_ok_n_o, power_stage_ok_oe_o;
  wire [5:0] pin;
  integer failures = 0, n_tests = 0;
  aspl_top #(.CLIP_MIN_CYC(CM), .SLEEP_REL_CYC(SR), .RUN_REL_CYC(RR), .RESTART_CYC(RS)) i_dut (.*);
  aspl_frontend i_fe (.clock_i(clock_i), .pin_o(pin), .starting_o(starting), .stopping_o(stopping),
    .oe_i({power_stage_ok_oe_o, running_flag_oe_o, sleep_flag_oe_o, fault_flag_oe_o, ch2_saturation_flag_oe_o,
    ch1_saturation_flag_oe_o}), .n_i({power_stage_ok_n_o, running_flag_n_o, sleep_flag_n_o, fault_flag_n_o,
    ch2_saturation_flag_n_o, ch1_saturation_flag_n_o}));
  initial forever #25 clock_i = ~clock_i;
  task ck(input logic [31:0] g, input logic [31:0] e);
  begin
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clock_i);
  endtask
  // Bounded wait, then judge the pin
  task wf(input integer i, input logic v, input integer lim);
    integer k;
  begin
    for (k = 0; k < lim && pin[i] !== v; k++)
      @(negedge clock_i);
    ck(pin[i], v);
  end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
  begin
    @(posedge clock_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1;
    // Only the watchdog ends a wait for pready
    @(posedge clock_i);
    while (pready_o !== 1'b1)
      @(posedge clock_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  end
  endtask
  task t_regs;
  begin
    apb(0, `ASPL_OFF_CTRL, 0);
    ck(rd, `ASPL_CTRL_RESET);
    apb(0, 12'h010, 0);
    ck(er, 1);
    apb(0, `ASPL_OFF_TEMP, 0);
    ck(rd, 32'h3);
    apb(1, `ASPL_OFF_CTRL, 32'h4);
    apb(0, `ASPL_OFF_CTRL, 0);
    ck(rd, 32'h4);
  end
  endtask
  task t_clip;
  begin
    clip_detect_i <= 2'h3;
    @(posedge clock_i);
    clip_detect_i <= 0;
    wf(0, 0, 6);
    wt(2);
    ck(pin[0], 0);
    ck(pin[1], 1);
    wf(0, 1, 10);
    apb(1, `ASPL_OFF_CTRL, 0);
    clip_detect_i <= 2'h3;
    wt(3 * CM);
    ck(pin[0], 0);
    ck(pin[1], 0);
    clip_detect_i <= 0;
    wf(0, 1, CM + 6);
  end
  endtask
  task t_fault;
    integer i;
  begin
    for (i = 0; i < 6; i++)
    begin
      {control_aux_overload_i, analog_aux_overload_i, sonic_excess_i, amp_overheat_i, overcurrent_i,
        supply_abnormal_i} <= 6'h1 << i;
      wf(2, 0, 8);
      wt(4);
      ck(amp_enable_o, 0);
      ck(pin[5], 1);
      ck(control_aux_enable_o, i != 5);
      if (i > 3)
        ck(analog_aux_enable_o, 0);
      {control_aux_overload_i, analog_aux_overload_i, sonic_excess_i, amp_overheat_i, overcurrent_i,
        supply_abnormal_i} <= 0;
      wf(2, 1, RS + 20);
      wf(5, 0, RS + 40);
      apb(0, `ASPL_OFF_CAUSE, 0);
      ck(rd, 32'h1 << i);
      apb(1, `ASPL_OFF_CAUSE, 32'h1 << i);
    end
  end
  endtask
  task t_heat;
  begin
    supply_overheat_i <= 1;
    supply_below_clear_i <= 0;
    wf(2, 0, 8);
    supply_overheat_i <= 0;
    wt(RS + 10);
    ck(pin[2], 0);
    supply_below_clear_i <= 1;
    wf(2, 1, RS + 20);
  end
  endtask
  task t_sleep;
  begin
    sleep_req_i <= 1;
    wf(3, 0, 8);
    wt(2);
    ck(pin[4], 0);
    ck(stopping, 1);
    wf(4, 1, RR + 6);
    remote_wake_i <= 1;
    wf(4, 0, 8);
    wt(2);
    ck(pin[3], 0);
    ck(starting, 1);
    wf(3, 1, SR + 6);
    remote_wake_i <= 0;
    wf(3, 0, 8);
    audio_presence_in_i <= 1;
    wf(4, 0, 8);
    sleep_req_i <= 0;
    audio_presence_in_i <= 0;
    wf(3, 1, SR + 6);
  end
  endtask
  task t_power;
  begin
    mains_present_i <= 0;
    wt(4);
    ck(pin[4], 0);
    wf(4, 1, RR + 8);
    mains_present_i <= 1;
    wf(4, 0, RS + 20);
    checks_passed_i <= 0;
    wf(5, 1, 8);
    checks_passed_i <= 1;
    wf(5, 0, RS + 20);
  end
  endtask
  task summarize;
  begin
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1;
    wf(5, 0, RS + 60);
    t_regs;
    t_clip;
    t_fault;
    t_heat;
    t_sleep;
    t_power;
    summarize;
  end
  // Far above the few hundred cycles the tests need
  initial
  begin
    #400000;
    failures++;
    summarize;
  end
endmodule // tb
bind aspl_top aspl_checker i_chk (.*);
